// ---- rmsm_pkg.sv ----
package rmsm_pkg;

    // Register offsets (page address)
    localparam logic [6:0] RMSM_ADDR_REF_FAIL_STATUS = 7'h02;
    localparam logic [6:0] RMSM_ADDR_LOOP_STATUS     = 7'h03;
    localparam logic [6:0] RMSM_ADDR_MON_FLAGS       = 7'h05;
    localparam logic [6:0] RMSM_ADDR_REF_IRQ_EN      = 7'h09;
    localparam logic [6:0] RMSM_ADDR_LOOP_IRQ_EN     = 7'h0A;
    localparam logic [6:0] RMSM_ADDR_MON_EN          = 7'h0C;
    localparam logic [6:0] RMSM_ADDR_DET_FREQ        = 7'h10;

    // Field positions
    localparam int RMSM_BIT_SCM    = 0;
    localparam int RMSM_BIT_CFM    = 1;
    localparam int RMSM_BIT_PFM    = 3;
    localparam int RMSM_BIT_LOCKED = 0;
    localparam int RMSM_BIT_LOST   = 1;
    localparam int RMSM_BIT_HOLD   = 2;

    // Reset values and the highest valid frequency code
    localparam logic [7:0] RMSM_RST_REF_IRQ_EN  = 8'h00;
    localparam logic [2:0] RMSM_RST_LOOP_IRQ_EN = 3'h0;
    localparam logic [7:0] RMSM_RST_MON_EN      = 8'hFF;
    localparam logic [3:0] RMSM_FREQ_UNKNOWN    = 4'hF;
    localparam logic [3:0] RMSM_FREQ_MAX_CODE   = 4'hA;

    // Monitor flag bits that can raise reference failure, bit 2 reserved
    localparam logic [3:0] RMSM_MON_FLAG_MASK   = 4'hB;

    // Register access from the host port
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } rmsm_req_t;

    // Monitor and loop events, one-cycle pulses
    typedef struct packed {
        logic scm_fail;
        logic cfm_fail;
        logic pfm_fail;
        logic locked;
        logic lost_lock;
        logic holdover;
    } rmsm_evt_t;

endpackage

// ---- rmsm_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmsm_regs
    import rmsm_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    // Register access
    input  wire rmsm_req_t  req_in,
    output logic [7:0]      rdata_out,
    // Monitor and loop events
    input  wire rmsm_evt_t  evt_in,
    input  wire logic       freq_valid_in,
    input  wire logic [3:0] freq_code_in,
    // Indications
    output logic            ref_fail_out,
    output logic            irq_out,
    output logic [7:0]      mon_enable_out
);

    logic [7:0] ref_irq_en;
    logic [2:0] loop_irq_en;
    logic [7:0] mon_en;
    logic [3:0] mon_flags;
    logic [2:0] loop_flags;
    logic [3:0] det_freq;
    logic [7:0] next_ref_irq_en;
    logic [2:0] next_loop_irq_en;
    logic [7:0] next_mon_en;
    logic [3:0] next_mon_flags;
    logic [2:0] next_loop_flags;
    logic [3:0] next_det_freq;
    logic [7:0] next_rdata;
    logic       next_ref_fail;
    logic       next_irq;
    logic [3:0] mon_evt;
    logic [2:0] loop_evt;

    // Address decode shared by the enable and sticky flag groups
    function automatic logic wr_hit(input rmsm_req_t r, input logic [6:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    function automatic logic rd_hit(input rmsm_req_t r, input logic [6:0] a);
        rd_hit = r.rd && (r.addr == a);
    endfunction

    // Event pulses in register bit order
    always_comb
    begin
        mon_evt = 4'h0;
        mon_evt[RMSM_BIT_SCM] = evt_in.scm_fail;
        mon_evt[RMSM_BIT_CFM] = evt_in.cfm_fail;
        mon_evt[RMSM_BIT_PFM] = evt_in.pfm_fail;
        loop_evt = 3'h0;
        loop_evt[RMSM_BIT_LOCKED] = evt_in.locked;
        loop_evt[RMSM_BIT_LOST]   = evt_in.lost_lock;
        loop_evt[RMSM_BIT_HOLD]   = evt_in.holdover;
    end

    // Enables: only software writes them
    always_comb
    begin
        next_ref_irq_en  = ref_irq_en;
        next_loop_irq_en = loop_irq_en;
        next_mon_en      = mon_en;
        if (wr_hit(req_in, RMSM_ADDR_REF_IRQ_EN))
            next_ref_irq_en = req_in.wdata;
        if (wr_hit(req_in, RMSM_ADDR_LOOP_IRQ_EN))
            next_loop_irq_en = req_in.wdata[2:0];
        if (wr_hit(req_in, RMSM_ADDR_MON_EN))
            next_mon_en = req_in.wdata;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            ref_irq_en     <= RMSM_RST_REF_IRQ_EN;
            loop_irq_en    <= RMSM_RST_LOOP_IRQ_EN;
            mon_en         <= RMSM_RST_MON_EN;
            mon_enable_out <= RMSM_RST_MON_EN;
        end
        else
        begin
            ref_irq_en     <= next_ref_irq_en;
            loop_irq_en    <= next_loop_irq_en;
            mon_en         <= next_mon_en;
            mon_enable_out <= next_mon_en;
        end
    end

    // Sticky flags: read clears, but a same-cycle event wins
    // so a failure arriving during the read is never lost
    always_comb
    begin
        next_mon_flags = mon_flags;
        if (rd_hit(req_in, RMSM_ADDR_MON_FLAGS))
            next_mon_flags = 4'h0;
        next_mon_flags = next_mon_flags | mon_evt;
        next_loop_flags = loop_flags;
        if (rd_hit(req_in, RMSM_ADDR_LOOP_STATUS))
            next_loop_flags = 3'h0;
        next_loop_flags = next_loop_flags | loop_evt;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            mon_flags  <= 4'h0;
            loop_flags <= 3'h0;
        end
        else
        begin
            mon_flags  <= next_mon_flags;
            loop_flags <= next_loop_flags;
        end
    end

    // Out-of-range codes are not trusted, last good code kept
    always_comb
    begin
        next_det_freq = det_freq;
        if (freq_valid_in && (freq_code_in <= RMSM_FREQ_MAX_CODE))
            next_det_freq = freq_code_in;
        else if (!freq_valid_in)
            next_det_freq = RMSM_FREQ_UNKNOWN;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
            det_freq <= RMSM_FREQ_UNKNOWN;
        else
            det_freq <= next_det_freq;
    end

    // Failure from sticky flags gated by monitor enables
    // Derived from sticky flags, so it stays until the flags are read or their monitor enables are written to zero
    always_comb
    begin
        next_ref_fail = |(next_mon_flags & mon_en[3:0] & RMSM_MON_FLAG_MASK);
        next_irq = (next_ref_fail & ref_irq_en[0])
                 | (|(next_loop_flags & loop_irq_en));
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            ref_fail_out <= 1'b0;
            irq_out      <= 1'b0;
        end
        else
        begin
            ref_fail_out <= next_ref_fail;
            irq_out      <= next_irq;
        end
    end

    // Read data holds between reads
    always_comb
    begin
        next_rdata = 8'h00;
        case (req_in.addr)
            RMSM_ADDR_REF_FAIL_STATUS: next_rdata = {7'h00, ref_fail_out};
            RMSM_ADDR_LOOP_STATUS:     next_rdata = {5'h00, loop_flags};
            RMSM_ADDR_MON_FLAGS:       next_rdata = {4'h0, mon_flags};
            RMSM_ADDR_REF_IRQ_EN:      next_rdata = ref_irq_en;
            RMSM_ADDR_LOOP_IRQ_EN:     next_rdata = {5'h00, loop_irq_en};
            RMSM_ADDR_MON_EN:          next_rdata = mon_en;
            RMSM_ADDR_DET_FREQ:        next_rdata = {4'h0, det_freq};
            default:                   next_rdata = 8'h00;
        endcase
        if (!req_in.rd)
            next_rdata = rdata_out;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
            rdata_out <= 8'h00;
        else
            rdata_out <= next_rdata;
    end

endmodule
`default_nettype wire

// ---- rmsm_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmsm_regs_monitor
    import rmsm_pkg::*;
(
    input wire logic       mclk_in,
    input wire logic       resetn_in,
    input wire rmsm_req_t  req_in,
    input wire logic [7:0] rdata_out,
    input wire rmsm_evt_t  evt_in,
    input wire logic       freq_valid_in,
    input wire logic       ref_fail_out,
    input wire logic       irq_out,
    input wire logic [7:0] mon_enable_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    wire rd5 = req_in.rd && req_in.addr == RMSM_ADDR_MON_FLAGS;
    wire rd3 = req_in.rd && req_in.addr == RMSM_ADDR_LOOP_STATUS;
    wire q = evt_in == '0;
    a_freq_unknown: assert property (req_in.rd && req_in.addr == RMSM_ADDR_DET_FREQ && !freq_valid_in
        && !$past(freq_valid_in) |=> rdata_out == 8'h0F) else $error("unknown code");
    a_scm_fail: assert property (evt_in.scm_fail && mon_enable_out[0] && !req_in.wr |=> ref_fail_out)
        else $error("scm");
    a_cfm_fail: assert property (evt_in.cfm_fail && mon_enable_out[1] && !req_in.wr |=> ref_fail_out)
        else $error("cfm");
    a_pfm_fail: assert property (evt_in.pfm_fail && mon_enable_out[3] && !req_in.wr |=> ref_fail_out)
        else $error("pfm");
    a_flags_clear: assert property (rd5 && q ##1 q |=> !ref_fail_out) else $error("flags");
    a_rdata_hold: assert property (!req_in.rd |=> $stable(rdata_out)) else $error("rdata");
    a_enable_write: assert property (req_in.wr && req_in.addr == RMSM_ADDR_MON_EN
        |=> mon_enable_out == $past(req_in.wdata)) else $error("enable");
    a_irq_clear: assert property (rd3 && q ##1 q ##1 rd5 && q |=> !irq_out) else $error("irq");
endmodule
bind rmsm_regs rmsm_regs_monitor rmsm_regs_monitor_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .req_in(req_in), .rdata_out(rdata_out), .evt_in(evt_in), .freq_valid_in(freq_valid_in),
    .ref_fail_out(ref_fail_out), .irq_out(irq_out), .mon_enable_out(mon_enable_out));
`default_nettype wire

// ---- rmsm_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmsm_regs_tb;
    import rmsm_pkg::*;
    logic       mclk_in = 0, resetn_in = 0, freq_valid_in = 0, ref_fail_out, irq_out, rf, iq;
    logic [2:0] lv;
    logic [3:0] freq_code_in = 0;
    logic [7:0] rdata_out, mon_enable_out, mf;
    rmsm_req_t  req_in = '0;
    rmsm_evt_t  evt_in = '0;
    int         failures = 0, comparisons = 0, en, ev, c, fq;
    rmsm_regs rmsm_regs_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in), .rdata_out(rdata_out),
        .evt_in(evt_in), .freq_valid_in(freq_valid_in), .freq_code_in(freq_code_in),
        .ref_fail_out(ref_fail_out), .irq_out(irq_out), .mon_enable_out(mon_enable_out));
    always #5 mclk_in = ~mclk_in;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Idle cycle between accesses keeps each strobe a clean pulse
    task acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(negedge mclk_in) req_in = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge mclk_in) req_in = '0;
    endtask
    task rd(input logic [6:0] a, input logic [7:0] exp);
        acc(0, a, 8'h00);
        chk(rdata_out, exp);
    endtask
    task end_sim;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Whole run is about 500 cycles, the timeout lies at 10000 cycles
    initial
    begin
        #100000;
        failures++;
        end_sim;
    end
    initial
    begin
        void'($urandom(32'h5F64EB17));
        repeat (6) @(negedge mclk_in);
        resetn_in = 1;
        chk(mon_enable_out, 8'hFF);
        rd(RMSM_ADDR_REF_IRQ_EN, 8'h00);
        rd(RMSM_ADDR_LOOP_IRQ_EN, 8'h00);
        rd(RMSM_ADDR_MON_EN, 8'hFF);
        rd(RMSM_ADDR_DET_FREQ, 8'h0F);
        rd(7'h7F, 8'h00);
        fq = 15;
        repeat (24)
        begin
            // Reserved enable bits stay at their default of one
            en = $urandom | 32'h0000_00F4;
            ev = $urandom_range(63);
            c = $urandom_range(14);
            if (c <= 10)
                fq = c;
            freq_valid_in = 1;
            freq_code_in = c[3:0];
            mf = {4'h0, ev[3], 1'b0, ev[4], ev[5]};
            lv = {ev[0], ev[1], ev[2]};
            rf = |(mf & en[7:0]);
            iq = (rf & en[16]) | (|(lv & en[10:8]));
            acc(1, RMSM_ADDR_MON_EN, en[7:0]);
            acc(1, RMSM_ADDR_REF_IRQ_EN, {7'h0, en[16]});
            acc(1, RMSM_ADDR_LOOP_IRQ_EN, {5'h0, en[10:8]});
            rd(RMSM_ADDR_MON_EN, en[7:0]);
            rd(RMSM_ADDR_DET_FREQ, {4'h0, fq[3:0]});
            @(negedge mclk_in) evt_in = ev[5:0];
            @(negedge mclk_in) evt_in = '0;
            chk({6'h0, irq_out, ref_fail_out}, {6'h0, iq, rf});
            rd(RMSM_ADDR_REF_FAIL_STATUS, {7'h0, rf});
            rd(RMSM_ADDR_MON_FLAGS, mf);
            rd(RMSM_ADDR_LOOP_STATUS, {5'h0, lv});
            rd(RMSM_ADDR_MON_FLAGS, 8'h00);
            chk({6'h0, irq_out, ref_fail_out}, 8'h00);
        end
        freq_valid_in = 0;
        rd(RMSM_ADDR_DET_FREQ, 8'h0F);
        end_sim;
    end
endmodule
`default_nettype wire
